//--- rtl/port3_timing_defs.svh
// Offsets, reset values and timing counts for the port 3 and cycle timing block
`ifndef PORT3_TIMING_DEFS_SVH
`define PORT3_TIMING_DEFS_SVH

`define CLK_PERIOD_NS      5
`define PORT_WIDTH         8
`define LATCH_RESET        8'hff
`define CYCLE_CLKS         4
`define TIMER_SLOW_CLKS    12
`define TIMER_DIV_LAST     4'hb
`define BOOST_NS           10
`define BOOST_CLKS         ((`BOOST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOST_W            2
`define STRAP_SETTLE       2'h2
`define MOVX_DPTR_CYCLES   3'h2
`define MOV_DIR_DIR_CYCLES 3'h3
`define MIN_INSTR_CYCLES   3'h1
`define MAX_INSTR_CYCLES   3'h5

`define BIT_SERIAL_RX      0
`define BIT_SERIAL_TX      1
`define BIT_IRQ_ZERO       2
`define BIT_IRQ_ONE        3
`define BIT_TIMER_ZERO     4
`define BIT_TIMER_ONE      5
`define BIT_WRITE_STROBE   6
`define BIT_READ_STROBE    7

`endif

//--- rtl/port3_timing_pkg.sv
// Types shared by the port 3 and cycle timing block
`include "port3_timing_defs.svh"

package port3_timing_pkg;

	typedef enum logic [1:0] {
		INSTR_IDLE = 2'b01,
		INSTR_RUN  = 2'b10
	} instr_state_t;

	typedef enum logic [1:0] {
		INSTR_PLAIN       = 2'h0,
		INSTR_MOVX_DPTR   = 2'h1,
		INSTR_MOV_DIR_DIR = 2'h2
	} instr_kind_t;

	typedef struct packed {
		logic [`PORT_WIDTH-1:0]                latch_reg;
		logic [`PORT_WIDTH-1:0]                eff_reg;
		logic [`PORT_WIDTH-1:0][`BOOST_W-1:0]  boost_cnt;
		logic [`PORT_WIDTH-1:0]                pin_s1;
		logic [`PORT_WIDTH-1:0]                pin_s2;
		logic                                  ea_s1;
		logic                                  ea_s2;
		logic [1:0]                            strap_wait;
		logic                                  strap_done;
		logic                                  fetch_ext;
		logic [1:0]                            phase;
		logic                                  ale;
		logic [3:0]                            tdiv;
		logic [1:0]                            tick;
		logic [7:0]                            addr_hi;
		instr_state_t                          ist;
		logic [2:0]                            left;
		logic                                  done;
	} state_t;

endpackage : port3_timing_pkg

//--- rtl/port3_cycle_timing.sv
// Port 3 pin logic, external-access strap, machine cycle and instruction timing
//
// How it works
// - Reset loads all eight port latch bits with one, pins weakly high.
// - A latch one with its alternate output high gives only a weak pullup, so outside drivers win.
// - Writing zero turns on strong pulldown until one written or reset.
// - A zero-to-one change gives a brief strong high, then the weak pullup.
// - Bit 0 is serial channel zero receive, bit 1 its transmit.
// - Bits 2 and 3 are external interrupt request inputs zero and one.
// - Bits 4 and 5 are the count inputs of timers zero and one.
// - Bit 6 drives the low write strobe, bit 7 the low read strobe.
// - External-access low fetches all code off-chip; high uses internal memory.
// - With external access low, internal data RAM stays reachable.
// - Port 2 drives the upper address byte on external bus cycles.
// - Each machine cycle is four clocks, with no dummy cycles.
// - Exactly one address-latch pulse in every machine cycle.
// - No idle dummy memory cycles; every machine cycle does work.
// - One machine cycle per instruction byte, one to five cycles.
// - External data move through the pointer takes two machine cycles.
// - Direct-to-direct move takes three machine cycles.
// - Timers tick every twelve clocks, or every four when selected.
// - Instruction effects match the standard set; only cycle counts differ.
`include "port3_timing_defs.svh"

module port3_cycle_timing
	import port3_timing_pkg::*;
(
	input  wire logic                   sys_clk,             // 200 MHz clock
	input  wire logic                   arst_n,              // Async reset, active low
	input  wire logic                   latch_wr,            // Port latch write pulse
	input  wire logic [`PORT_WIDTH-1:0] latch_wr_data,       // Port latch write value
	input  wire logic [`PORT_WIDTH-1:0] pin_in,              // Pin levels from pads
	output logic      [`PORT_WIDTH-1:0] pin_out,             // Pin drive level
	output logic      [`PORT_WIDTH-1:0] pin_oe,              // Strong drive enable
	output logic      [`PORT_WIDTH-1:0] weak_pullup_en,      // Weak pullup enable
	output logic      [`PORT_WIDTH-1:0] latch_value,         // Port latch contents
	output logic      [`PORT_WIDTH-1:0] pin_level,           // Synchronised pin levels
	input  wire logic                   serial0_tx_drive,    // Transmit data from serial core
	input  wire logic                   wr_strobe_n,         // Data write strobe from core
	input  wire logic                   rd_strobe_n,         // Data read strobe from core
	output logic                        serial0_receive_in,  // Receive data to serial core
	output logic                        ext_irq_zero,        // Interrupt request 0 level
	output logic                        ext_irq_one,         // Interrupt request 1 level
	output logic                        timer_zero_count_in, // Timer 0 count input
	output logic                        timer_one_count_in,  // Timer 1 count input
	input  wire logic                   external_access_n,   // Strap pin, low = external code
	output logic                        code_fetch_external, // Code fetched off-chip
	output logic                        strap_valid,         // Strap has been captured
	output logic                        data_ram_internal,   // Internal data RAM reachable
	input  wire logic                   ext_bus_active,      // External bus cycle in progress
	input  wire logic [7:0]             ext_addr_hi,         // Upper address byte
	output logic      [7:0]             port2_addr_out,      // Upper address to port 2
	output logic                        ale,                 // Address latch enable
	output logic      [1:0]             cycle_phase,         // Clock within machine cycle
	input  wire logic [1:0]             timer_fast,          // Per timer: four-clock rate
	output logic      [1:0]             timer_tick,          // Per timer count enable pulse
	input  wire logic                   instr_start,         // Start an instruction
	input  wire instr_kind_t            instr_kind,          // Timing class of instruction
	input  wire logic [2:0]             instr_bytes,         // Instruction length in bytes
	output logic                        instr_ready,         // Start is taken this cycle
	output logic                        instr_done           // Last machine cycle ended
);

	localparam logic [`BOOST_W-1:0] BOOST_LOAD = `BOOST_W'(`BOOST_CLKS);

	state_t                   st_reg;
	state_t                   st_next;
	logic [`PORT_WIDTH-1:0]   alt_drive;
	logic [`PORT_WIDTH-1:0]   eff;
	logic [`PORT_WIDTH-1:0]   boost_on;
	logic [2:0]               cycles;

	// Alternate outputs AND into the latch, so a latch zero always wins
	always_comb begin
		alt_drive                    = {`PORT_WIDTH{1'b1}};
		alt_drive[`BIT_SERIAL_TX]    = serial0_tx_drive;
		alt_drive[`BIT_WRITE_STROBE] = wr_strobe_n;
		alt_drive[`BIT_READ_STROBE]  = rd_strobe_n;
	end

	assign eff = st_reg.latch_reg & alt_drive;

	// Timing is all this block models; results are left to the core unchanged
	always_comb begin
		case (instr_kind)
			INSTR_MOVX_DPTR:   cycles = `MOVX_DPTR_CYCLES;
			INSTR_MOV_DIR_DIR: cycles = `MOV_DIR_DIR_CYCLES;
			default: begin
				if (instr_bytes < `MIN_INSTR_CYCLES) begin
					cycles = `MIN_INSTR_CYCLES;
				end else if (instr_bytes > `MAX_INSTR_CYCLES) begin
					cycles = `MAX_INSTR_CYCLES;
				end else begin
					cycles = instr_bytes;
				end
			end
		endcase
	end

	always_comb begin
		st_next = st_reg;
		// Pads are asynchronous to the core clock
		st_next.pin_s1 = pin_in;
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.ea_s1  = external_access_n;
		st_next.ea_s2  = st_reg.ea_s1;

		if (latch_wr) begin
			st_next.latch_reg = latch_wr_data;
		end
		st_next.eff_reg = eff;
		for (int i = 0; i < `PORT_WIDTH; i++) begin
			if (eff[i] && !st_reg.eff_reg[i]) begin
				st_next.boost_cnt[i] = BOOST_LOAD;
			end else if (!eff[i]) begin
				st_next.boost_cnt[i] = '0;
			end else if (st_reg.boost_cnt[i] != '0) begin
				st_next.boost_cnt[i] = st_reg.boost_cnt[i] - 1'b1;
			end
		end

		// Strap is read once, after the synchroniser has filled
		if (!st_reg.strap_done) begin
			if (st_reg.strap_wait == `STRAP_SETTLE) begin
				st_next.fetch_ext  = !st_reg.ea_s2;
				st_next.strap_done = 1'b1;
			end else begin
				st_next.strap_wait = st_reg.strap_wait + 1'b1;
			end
		end

		if (ext_bus_active) begin
			st_next.addr_hi = ext_addr_hi;
		end

		// Free-running four-clock cycle; no stretch or dummy state exists
		st_next.phase = st_reg.phase + 1'b1;
		st_next.ale   = (st_reg.phase == 2'h3);
		st_next.tdiv  = (st_reg.tdiv == `TIMER_DIV_LAST) ? 4'h0 : st_reg.tdiv + 1'b1;
		for (int t = 0; t < 2; t++) begin
			st_next.tick[t] = timer_fast[t] ? (st_reg.phase == 2'h3)
			                                : (st_reg.tdiv == `TIMER_DIV_LAST);
		end

		st_next.done = 1'b0;
		case (st_reg.ist)
			INSTR_IDLE: begin
				if (instr_start && st_reg.phase == 2'h0) begin
					st_next.left = cycles;
					st_next.ist  = INSTR_RUN;
				end
			end
			INSTR_RUN: begin
				if (st_reg.phase == 2'h3) begin
					if (st_reg.left == 3'h1) begin
						st_next.done = 1'b1;
						st_next.ist  = INSTR_IDLE;
					end else begin
						st_next.left = st_reg.left - 1'b1;
					end
				end
			end
			default: st_next.ist = INSTR_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg            <= '0;
			st_reg.latch_reg  <= `LATCH_RESET;
			st_reg.eff_reg    <= `LATCH_RESET;
			st_reg.pin_s1     <= `LATCH_RESET;
			st_reg.pin_s2     <= `LATCH_RESET;
			st_reg.ea_s1      <= 1'b1;
			st_reg.ea_s2      <= 1'b1;
			st_reg.ale        <= 1'b1;
			st_reg.ist        <= INSTR_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		for (int i = 0; i < `PORT_WIDTH; i++) begin
			boost_on[i] = (st_reg.boost_cnt[i] != '0);
		end
	end

	assign pin_out        = st_reg.eff_reg;
	assign pin_oe         = ~st_reg.eff_reg | boost_on;
	assign weak_pullup_en = st_reg.eff_reg;
	assign latch_value    = st_reg.latch_reg;
	assign pin_level      = st_reg.pin_s2;

	assign serial0_receive_in  = st_reg.pin_s2[`BIT_SERIAL_RX];
	assign ext_irq_zero        = st_reg.pin_s2[`BIT_IRQ_ZERO];
	assign ext_irq_one         = st_reg.pin_s2[`BIT_IRQ_ONE];
	assign timer_zero_count_in = st_reg.pin_s2[`BIT_TIMER_ZERO];
	assign timer_one_count_in  = st_reg.pin_s2[`BIT_TIMER_ONE];

	// Only code fetches move off-chip; data RAM decode is never switched away
	assign code_fetch_external = st_reg.fetch_ext;
	assign strap_valid         = st_reg.strap_done;
	assign data_ram_internal   = 1'b1;
	assign port2_addr_out      = st_reg.addr_hi;

	assign ale         = st_reg.ale;
	assign cycle_phase = st_reg.phase;
	assign timer_tick  = st_reg.tick;
	assign instr_ready = (st_reg.ist == INSTR_IDLE) && (st_reg.phase == 2'h0);
	assign instr_done  = st_reg.done;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	sequence ale_gap_s;
		!ale [*3] ##1 ale;
	endsequence

	sequence boost_hold_s;
		pin_oe[0] [*2] ##1 (pin_oe[0] == !pin_out[0]);
	endsequence

	// A latch held at one long enough for any boost to expire leaves only the weak pullup
	weak_high_only_a: assert property (latch_value[2] [*4] |-> !pin_oe[2])
		else $error("weak pullup pin is strongly driven");

	pulldown_on_zero_a: assert property (latch_wr |=> ##1
		((pin_oe & ~pin_out & ~$past(latch_wr_data, 2)) == ~$past(latch_wr_data, 2)))
		else $error("written zero did not give strong pulldown");

	boost_pulse_a: assert property ($rose(pin_out[0]) |-> boost_hold_s)
		else $error("strong pull-high pulse has wrong length");

	rx_follows_pin_a: assert property (serial0_receive_in == $past(pin_in[0], 2))
		else $error("serial receive does not follow pin 0");

	tx_drives_pin_a: assert property (!serial0_tx_drive |=> (pin_oe[1] && !pin_out[1]))
		else $error("transmit low not driven on pin 1");

	irq_follows_pin_a: assert property (ext_irq_one == $past(pin_in[3], 2))
		else $error("interrupt one does not follow pin 3");

	strobe_on_pin_a: assert property (!wr_strobe_n |=> (pin_oe[6] && !pin_out[6]))
		else $error("write strobe not driven low on pin 6");

	strap_stable_a: assert property (strap_valid |=> $stable(code_fetch_external) && strap_valid)
		else $error("code fetch source changed after strap");

	upper_addr_a: assert property (ext_bus_active |=> port2_addr_out == $past(ext_addr_hi))
		else $error("port 2 does not carry upper address");

	ale_once_a: assert property (ale |=> ale_gap_s)
		else $error("address latch pulse not once per four clocks");

	ale_phase_a: assert property (ale == (cycle_phase == 2'h0))
		else $error("address latch pulse off machine cycle start");

	slow_tick_a: assert property (timer_tick[0] && !$past(timer_fast[0]) |-> ##12 timer_tick[0])
		else $error("slow timer tick not every twelve clocks");

	// The taking edge may still see the previous done pulse, so the quiet time starts one later
	movx_time_a: assert property (instr_start && instr_ready && instr_kind == INSTR_MOVX_DPTR
		|-> ##1 (!instr_done [*7] ##1 instr_done))
		else $error("pointer data move not eight clocks");

	movdd_time_a: assert property (instr_start && instr_ready && instr_kind == INSTR_MOV_DIR_DIR
		|-> ##12 instr_done)
		else $error("direct move not twelve clocks");

	irq_zero_pin_a: assert property (ext_irq_zero == $past(pin_in[2], 2))
		else $error("interrupt zero does not follow pin 2");

	count_inputs_pin_a: assert property ({timer_one_count_in, timer_zero_count_in} == $past(pin_in[5:4], 2))
		else $error("timer count inputs do not follow pins 4 and 5");

	read_strobe_pin_a: assert property (!rd_strobe_n |=> (pin_oe[7] && !pin_out[7]))
		else $error("read strobe not driven low on pin 7");

	zero_latch_pin_a: assert property (!latch_value[2] [*2] |-> (pin_oe[2] && !pin_out[2]))
		else $error("latch zero on pin 2 not strongly pulled down");

	// Both rates tick on machine cycle starts, so only the last select matters
	fast_tick_a: assert property (timer_tick[1] && $past(timer_fast[1]) ##3 timer_fast[1] |=> timer_tick[1])
		else $error("fast timer tick not every four clocks");

	done_single_a: assert property (instr_done |=> !instr_done)
		else $error("instruction done pulse longer than one clock");

	done_then_ready_a: assert property (instr_done |-> instr_ready)
		else $error("not ready for a start in the done cycle");

	one_cycle_instr_a: assert property (instr_start && instr_ready && instr_kind == INSTR_PLAIN && instr_bytes == 3'h1
		|-> ##1 (!instr_done [*3] ##1 instr_done))
		else $error("one byte instruction not four clocks");

	longest_instr_a: assert property (instr_start && instr_ready && instr_kind == INSTR_PLAIN && instr_bytes > 3'h5
		|-> ##20 instr_done)
		else $error("long instruction not capped at five machine cycles");

endmodule : port3_cycle_timing

//--- verification/port3_board_model.sv
// Board model that resolves each port 3 pad from device drive, pullups and outside drivers
module port3_board_model (
	input  wire logic [7:0] pin_out,        // Device drive level
	input  wire logic [7:0] pin_oe,         // Device strong drive enable
	input  wire logic [7:0] weak_pullup_en, // Device weak pullup
	input  wire logic [7:0] ext_en,         // Outside driver enable
	input  wire logic [7:0] ext_val,        // Outside driver level
	output logic      [7:0] pin_in          // Resolved pad level
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i]; // Outside driver overcomes the weak pullup
			else
				pin_in[i] = 1'b1; // Board pull-up, so a released pad never keeps a stale low
		end
	end
endmodule : port3_board_model

//--- verification/port3_and_cycle_timing_tb_top.sv
// Self-checking bench for port 3 pin logic, strap capture and cycle timing
module port3_and_cycle_timing_tb_top
	import port3_timing_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, arst_n, latch_wr, serial0_tx_drive, wr_strobe_n, rd_strobe_n;
	logic        external_access_n, ext_bus_active, instr_start, instr_ready, instr_done;
	logic        serial0_receive_in, ext_irq_zero, ext_irq_one, timer_zero_count_in, timer_one_count_in;
	logic        code_fetch_external, strap_valid, data_ram_internal, ale;
	logic [7:0]  latch_wr_data, pin_in, ext_en, ext_val, ext_addr_hi, v;
	logic [7:0]  pin_out, pin_oe, weak_pullup_en, latch_value, pin_level, port2_addr_out;
	logic [1:0]  timer_fast, cycle_phase, timer_tick;
	logic [2:0]  instr_bytes;
	logic [31:0] rnd;
	instr_kind_t instr_kind;
	int          mismatches = 0, compares = 0, cycles = 0, n, k;

	port3_cycle_timing dut (.sys_clk(sys_clk), .arst_n(arst_n), .latch_wr(latch_wr),
		.latch_wr_data(latch_wr_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.weak_pullup_en(weak_pullup_en), .latch_value(latch_value), .pin_level(pin_level),
		.serial0_tx_drive(serial0_tx_drive), .wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n),
		.serial0_receive_in(serial0_receive_in), .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one),
		.timer_zero_count_in(timer_zero_count_in), .timer_one_count_in(timer_one_count_in),
		.external_access_n(external_access_n), .code_fetch_external(code_fetch_external),
		.strap_valid(strap_valid), .data_ram_internal(data_ram_internal), .ext_bus_active(ext_bus_active),
		.ext_addr_hi(ext_addr_hi), .port2_addr_out(port2_addr_out), .ale(ale), .cycle_phase(cycle_phase),
		.timer_fast(timer_fast), .timer_tick(timer_tick), .instr_start(instr_start),
		.instr_kind(instr_kind), .instr_bytes(instr_bytes), .instr_ready(instr_ready),
		.instr_done(instr_done));
	port3_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .weak_pullup_en(weak_pullup_en),
		.ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic int cyc(input instr_kind_t kd, input logic [2:0] b);
		if (kd == INSTR_MOVX_DPTR)
			return 8;
		if (kd == INSTR_MOV_DIR_DIR)
			return 12;
		return 4 * ((b == 3'h0) ? 1 : (b > 3'h5) ? 5 : int'(b));
	endfunction : cyc
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int c);
		repeat (c) @(negedge sys_clk);
	endtask : tick
	task automatic summarize();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	task automatic reset_dut(input logic strap);
		external_access_n = strap;
		arst_n = 1'b0;
		tick(10);
		arst_n = 1'b1;
		tick(5);
	endtask : reset_dut
	task automatic wr(input logic [7:0] d);
		latch_wr = 1'b1;
		latch_wr_data = d;
		tick(1);
		latch_wr = 1'b0;
	endtask : wr
	task automatic run_instr(input instr_kind_t kd, input logic [2:0] b);
		for (n = 0; n < 8 && instr_ready !== 1'b1; n++)
			tick(1);
		instr_kind = kd;
		instr_bytes = b;
		instr_start = 1'b1;
		for (n = 1; n <= 40; n++) begin
			tick(1);
			instr_start = 1'b0;
			if (instr_done === 1'b1)
				break;
		end
		check(n, cyc(kd, b));
		check(instr_ready, 1'b1);
	endtask : run_instr

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Hang guard, far above the roughly 490 cycles the sequence needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			summarize();
		end
	end

	initial begin
		{latch_wr, latch_wr_data, ext_en, ext_val, ext_bus_active, ext_addr_hi, instr_start} = '0;
		{serial0_tx_drive, wr_strobe_n, rd_strobe_n} = 3'h7;
		timer_fast = 2'h0;
		instr_kind = INSTR_PLAIN;
		instr_bytes = 3'h1;
		rnd = 32'h4b73;
		reset_dut(1'b0);
		check({latch_value, pin_out, weak_pullup_en, pin_oe}, 32'hffffff00);
		check({code_fetch_external, strap_valid, data_ram_internal}, 3'h7);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			v = (i == 0) ? 8'h00 : rnd[7:0];
			wr(v);
			tick(1);
			check(latch_value, v);
			tick(1);
			check({pin_out, pin_oe}, {v, 8'(~v)});
			wr(8'hff);
			tick(2);
			check(pin_oe, 8'(~v));
			check(pin_level, v);
			tick(2);
			check({pin_oe, weak_pullup_en}, 16'h00ff);
		end
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			ext_en = (i == 0) ? 8'hff : rnd[7:0];
			tick(3);
			check(pin_level, 8'(~ext_en));
			check({timer_one_count_in, timer_zero_count_in, ext_irq_one, ext_irq_zero, serial0_receive_in},
				{~ext_en[5:2], ~ext_en[0]});
		end
		ext_en = 8'h00;
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			{rd_strobe_n, wr_strobe_n, serial0_tx_drive} = rnd[2:0];
			tick(2);
			check({pin_out[7:6], pin_out[1]}, rnd[2:0]);
		end
		{serial0_tx_drive, wr_strobe_n, rd_strobe_n} = 3'h7;
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			ext_bus_active = 1'b1;
			ext_addr_hi = (i == 0) ? 8'h80 : rnd[7:0];
			v = ext_addr_hi;
			tick(1);
			ext_bus_active = 1'b0;
			ext_addr_hi = ~v;
			tick(2);
			check(port2_addr_out, v);
		end
		n = 0;
		k = 0;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			n += (ale === 1'b1);
			k += (ale !== (cycle_phase == 2'h0));
		end
		check(n, 10);
		check(k, 0);
		for (int f = 0; f < 4; f++) begin
			timer_fast = f[1:0];
			tick(4);
			n = 0;
			k = 0;
			for (int i = 0; i < 48; i++) begin
				tick(1);
				n += (timer_tick[0] === 1'b1);
				k += (timer_tick[1] === 1'b1);
			end
			check(n, f[0] ? 12 : 4);
			check(k, f[1] ? 12 : 4);
		end
		for (int b = 0; b < 8; b++)
			run_instr(INSTR_PLAIN, 3'(b));
		run_instr(INSTR_MOVX_DPTR, 3'h3);
		run_instr(INSTR_MOV_DIR_DIR, 3'h1);
		wr(8'h00);
		tick(3);
		reset_dut(1'b1);
		check({latch_value, pin_oe}, 16'hff00);
		check({code_fetch_external, strap_valid}, 2'h1);
		summarize();
	end
endmodule : port3_and_cycle_timing_tb_top
